// [core/trb_defs.svh]
// timing counts, widths and reset values for the trellis receiver back end
// assumes inclusion by bare name from the package, whose macros the top module also uses
`ifndef TRB_DEFS_SVH
`define TRB_DEFS_SVH
`define TRB_HALF_W 16
`define TRB_TRACEBACK_DEPTH 16
`define TRB_RING_FRAME 8
`define TRB_HIST_RESET 16'h0000
`define TRB_SYM_RESET 16'h0000
`define TRB_FIFO_DEPTH 16
`define TRB_DESCR_TAP_A 18
`define TRB_DESCR_TAP_B 23
`endif

// [core/trb_fifo.sv]
// synchronous valid/ready fifo, width and depth as parameters
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module trb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic doWrite;
  logic doRead;
  assign inReady = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;
  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule : trb_fifo

// [core/trb_pkg.sv]
// types shared by the trellis receiver back end
// assumes trb_defs.svh is on the include path
package trb_pkg;
  `include "trb_defs.svh"
  typedef logic signed [`TRB_HALF_W-1:0] trb_half_t;
  typedef enum logic [1:0] {TRB_IDLE, TRB_SUM, TRB_EMIT} trb_state_e;
endpackage : trb_pkg

// [core/trb_receiver_backend.sv]
// trellis receiver back end: compare-select helper, inverse precoder, inverse mapper
// assumes decisions arrive from same-clock decoder logic; one clock, async active-low reset
`timescale 1ns/1ps
module trb_receiver_backend
  import trb_pkg::*;
#(
  parameter int Q_BITS = 2,
  parameter int COORD_W = 4,
  parameter int IDX_W = 8,
  parameter int DMEM_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  // compare-select port
  input wire logic cmpValid,
  input wire logic [31:0] cmpAcc,
  input wire logic [$clog2(DMEM_DEPTH)-1:0] cmpAddr,
  output logic [15:0] transitionHistory,
  output logic testConditionFlag,
  input wire logic [$clog2(DMEM_DEPTH)-1:0] dmemRdAddr,
  output logic [15:0] dmemRdData,
  input wire logic [3:0] tracebackStart,
  output logic [3:0] tracebackState,
  // coefficients learned during training
  input wire logic signed [15:0] coef1Re,
  input wire logic signed [15:0] coef1Im,
  input wire logic signed [15:0] coef2Re,
  input wire logic signed [15:0] coef2Im,
  input wire logic signed [15:0] coef3Re,
  input wire logic signed [15:0] coef3Im,
  // decoder decisions in, recovered symbols out
  input wire logic decValid,
  output logic decReady,
  input wire logic signed [15:0] decRe,
  input wire logic signed [15:0] decIm,
  output logic signed [15:0] symRe,
  output logic signed [15:0] symIm,
  // inverse mapper inputs and outputs
  input wire logic [COORD_W-1:0] pointX,
  input wire logic [COORD_W-1:0] pointY,
  input wire logic [2:0] rotBits,
  input wire logic lutWrite,
  input wire logic [2*COORD_W-1:0] lutAddr,
  input wire logic [IDX_W-1:0] lutData,
  input wire logic [15:0] shellBits,
  output logic [`TRB_RING_FRAME*(IDX_W-Q_BITS)-1:0] ringFrame,
  output logic ringFrameValid,
  output logic [15:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int RING_W = IDX_W - Q_BITS;
  localparam int AW = $clog2(DMEM_DEPTH);

  function automatic trb_half_t cmul_part(input trb_half_t a, input trb_half_t b, input trb_half_t c,
                                          input trb_half_t d);
    logic signed [31:0] p;
    p = 32'(a) * 32'(b) - 32'(c) * 32'(d);
    return p[29:14];
  endfunction : cmul_part

  // quantize to the even lattice used in the transmitter's modulo step
  function automatic trb_half_t quant(input trb_half_t v);
    return {v[15:9], 9'h000};
  endfunction : quant

  // ---- compare-select unit
  logic [15:0] dmem [DMEM_DEPTH];
  logic [15:0] transition_history_reg;
  logic testCond_reg;
  logic [15:0] dmemRd_reg;
  logic cmpDecision;
  trb_half_t hiHalf;
  trb_half_t loHalf;
  assign hiHalf = cmpAcc[31:16];
  assign loHalf = cmpAcc[15:0];
  assign cmpDecision = (hiHalf < loHalf);
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      transition_history_reg <= `TRB_HIST_RESET;
      testCond_reg <= 1'b0;
    end else if (cmpValid) begin
      transition_history_reg <= {transition_history_reg[14:0], cmpDecision};
      testCond_reg <= cmpDecision;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (cmpValid) begin
      dmem[cmpAddr] <= cmpDecision ? loHalf : hiHalf;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dmemRd_reg <= 16'h0000;
    end else begin
      dmemRd_reg <= dmem[dmemRdAddr];
    end
  end
  assign transitionHistory = transition_history_reg;
  assign testConditionFlag = testCond_reg;
  assign dmemRdData = dmemRd_reg;

  // traceback walks the stored decisions back sixteen intervals
  logic [3:0] tbState_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tbState_reg <= 4'h0;
    end else if (cmpValid) begin
      tbState_reg <= {tracebackStart[2:0], transition_history_reg[`TRB_TRACEBACK_DEPTH-1]};
    end
  end
  assign tracebackState = tbState_reg;

  // ---- inverse precoder
  trb_state_e state_reg;
  trb_half_t histRe_reg [3];
  trb_half_t histIm_reg [3];
  trb_half_t yRe_reg;
  trb_half_t yIm_reg;
  trb_half_t pRe_reg;
  trb_half_t pIm_reg;
  trb_half_t symRe_reg;
  trb_half_t symIm_reg;
  logic symValid_reg;
  trb_half_t qRe;
  trb_half_t qIm;
  logic fifoInReady;
  assign qRe = cmul_part(coef1Re, histRe_reg[0], coef1Im, histIm_reg[0])
             + cmul_part(coef2Re, histRe_reg[1], coef2Im, histIm_reg[1])
             + cmul_part(coef3Re, histRe_reg[2], coef3Im, histIm_reg[2]);
  assign qIm = cmul_part(coef1Re, histIm_reg[0], -coef1Im, histRe_reg[0])
             + cmul_part(coef2Re, histIm_reg[1], -coef2Im, histRe_reg[1])
             + cmul_part(coef3Re, histIm_reg[2], -coef3Im, histRe_reg[2]);
  // stall intake while the fifo is full or a symbol is still on its way in, so no symbol is dropped;
  // costs one cycle per decision
  assign decReady = (state_reg == TRB_IDLE) && fifoInReady && !symValid_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= TRB_IDLE;
      yRe_reg <= `TRB_SYM_RESET;
      yIm_reg <= `TRB_SYM_RESET;
      pRe_reg <= `TRB_SYM_RESET;
      pIm_reg <= `TRB_SYM_RESET;
    end else begin
      case (state_reg)
        TRB_IDLE: begin
          if (decValid && decReady) begin
            yRe_reg <= decRe;
            yIm_reg <= decIm;
            state_reg <= TRB_SUM;
          end
        end
        TRB_SUM: begin
          pRe_reg <= {qRe[15:1], 1'b0};
          pIm_reg <= {qIm[15:1], 1'b0};
          state_reg <= TRB_EMIT;
        end
        TRB_EMIT: begin
          state_reg <= TRB_IDLE;
        end
        default: begin
          state_reg <= TRB_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 3; i++) begin
        histRe_reg[i] <= `TRB_SYM_RESET;
        histIm_reg[i] <= `TRB_SYM_RESET;
      end
    end else if (state_reg == TRB_EMIT) begin
      histRe_reg[0] <= yRe_reg - pRe_reg;
      histIm_reg[0] <= yIm_reg - pIm_reg;
      histRe_reg[1] <= histRe_reg[0];
      histIm_reg[1] <= histIm_reg[0];
      histRe_reg[2] <= histRe_reg[1];
      histIm_reg[2] <= histIm_reg[1];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      symRe_reg <= `TRB_SYM_RESET;
      symIm_reg <= `TRB_SYM_RESET;
      symValid_reg <= 1'b0;
    end else begin
      symValid_reg <= (state_reg == TRB_EMIT);
      if (state_reg == TRB_EMIT) begin
        symRe_reg <= yRe_reg - quant(pRe_reg);
        symIm_reg <= yIm_reg - quant(pIm_reg);
      end
    end
  end
  assign symRe = symRe_reg;
  assign symIm = symIm_reg;

  // ---- inverse mapper
  logic [IDX_W-1:0] invLut [1 << (2*COORD_W)];
  logic [IDX_W-1:0] pointIdx;
  logic [RING_W-1:0] ringBuf_reg [`TRB_RING_FRAME];
  logic [2:0] ringCnt_reg;
  logic ringFrameValid_reg;
  logic [2:0] prevRot_reg;
  logic [2:0] iBits;
  logic u0Bit;
  logic [22:0] descr_reg;
  logic [15:0] merged;
  logic [15:0] plain;
  logic [22:0] descrNext;
  always_ff @(posedge sys_clk) begin
    if (lutWrite) begin
      invLut[lutAddr] <= lutData;
    end
  end
  assign pointIdx = invLut[{pointX, pointY}];
  // differential decode: I bits are the change of rotation since the previous symbol
  assign iBits = rotBits - prevRot_reg;
  assign u0Bit = ^(rotBits ^ prevRot_reg);
  // reverse parser order: I bits, then Q bits, then S bits
  assign merged = 16'({shellBits[15-Q_BITS-4:0], pointIdx[Q_BITS-1:0], u0Bit, iBits});
  always_comb begin
    descrNext = descr_reg;
    plain = 16'h0000;
    for (int b = 0; b < 16; b++) begin
      plain[b] = merged[b] ^ descrNext[`TRB_DESCR_TAP_A-1] ^ descrNext[`TRB_DESCR_TAP_B-1];
      descrNext = {descrNext[21:0], merged[b]};
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ringCnt_reg <= 3'h0;
      ringFrameValid_reg <= 1'b0;
      prevRot_reg <= 3'h0;
      descr_reg <= 23'h000000;
      for (int i = 0; i < `TRB_RING_FRAME; i++) begin
        ringBuf_reg[i] <= '0;
      end
    end else begin
      ringFrameValid_reg <= 1'b0;
      if (symValid_reg && fifoInReady) begin
        ringBuf_reg[ringCnt_reg] <= pointIdx[IDX_W-1:Q_BITS];
        ringCnt_reg <= ringCnt_reg + 3'h1;
        ringFrameValid_reg <= (ringCnt_reg == 3'(`TRB_RING_FRAME-1));
        prevRot_reg <= rotBits;
        descr_reg <= descrNext;
      end
    end
  end
  always_comb begin
    ringFrame = '0;
    for (int i = 0; i < `TRB_RING_FRAME; i++) begin
      ringFrame[i*RING_W +: RING_W] = ringBuf_reg[i];
    end
  end
  assign ringFrameValid = ringFrameValid_reg;

  trb_fifo #(.WIDTH(16), .DEPTH(`TRB_FIFO_DEPTH)) u_outFifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .inData(plain),
    .inValid(symValid_reg),
    .inReady(fifoInReady),
    .outData(outData),
    .outValid(outValid),
    .outReady(outReady)
  );
endmodule : trb_receiver_backend

// [testbench/tb.sv]
// self-checking bench for the trellis receiver back end
// assumes the decoder model drives decisions and the checker is bound to the top
`timescale 1ns/1ps
module tb;
  logic sys_clk, rst_b, cmpValid, lutWrite, outReady, modelOn, modelSlow, decValid, decReady;
  logic testConditionFlag, ringFrameValid, outValid;
  logic [31:0] cmpAcc, acc;
  logic [3:0] cmpAddr, dmemRdAddr, tracebackStart, pointX, pointY, pend = 4'h0;
  logic [3:0] tbSt, tbIn, tbExp;
  logic [2:0] rotBits;
  logic [7:0] lutAddr, lutData, pt, lut;
  logic [15:0] shellBits, transitionHistory, dmemRdData, outData, hist, big;
  logic signed [15:0] decRe, decIm, symRe, symIm;
  logic signed [15:0] coef [6];
  logic [47:0] ringFrame;
  logic [31:0] symQ [$];
  logic [47:0] ringQ [$];
  integer seed = 42212;
  int i, w, t0, takes, nOut, nFrames, comparisons, nMismatch;

  trb_receiver_backend i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .cmpValid(cmpValid), .cmpAcc(cmpAcc), .cmpAddr(cmpAddr),
    .transitionHistory(transitionHistory), .testConditionFlag(testConditionFlag), .dmemRdAddr(dmemRdAddr),
    .dmemRdData(dmemRdData), .tracebackStart(tracebackStart), .tracebackState(tbSt),
    .coef1Re(coef[0]), .coef1Im(coef[1]), .coef2Re(coef[2]), .coef2Im(coef[3]), .coef3Re(coef[4]),
    .coef3Im(coef[5]), .decValid(decValid), .decReady(decReady), .decRe(decRe), .decIm(decIm),
    .symRe(symRe), .symIm(symIm), .pointX(pointX), .pointY(pointY), .rotBits(rotBits), .lutWrite(lutWrite),
    .lutAddr(lutAddr), .lutData(lutData), .shellBits(shellBits), .ringFrame(ringFrame),
    .ringFrameValid(ringFrameValid), .outData(outData), .outValid(outValid), .outReady(outReady));
  trb_decoder_model i_dec (.sys_clk(sys_clk), .rst_b(rst_b), .enable(modelOn), .slow(modelSlow),
    .decReady(decReady), .decValid(decValid), .decRe(decRe), .decIm(decIm));

  task automatic check(input logic [63:0] seen, input logic [63:0] expd);
    comparisons++;
    if (seen !== expd) begin
      nMismatch++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // notes expectations at each taken decision; one point per frame makes slot order irrelevant
  always @(posedge sys_clk) begin
    if (rst_b && decValid && decReady) begin
      symQ.push_back({decRe, decIm});
      if (takes % 8 == 0) begin
        pt = 8'($random(seed));
        lut = pt ^ 8'h5A;
        pointX <= pt[7:4];
        pointY <= pt[3:0];
        ringQ.push_back({8{lut[7:2]}});
      end
      rotBits <= 3'($random(seed));
      shellBits <= 16'($random(seed));
      takes <= takes + 1;
    end
  end

  always @(posedge sys_clk) begin
    pend <= {pend[2:0], rst_b && decValid && decReady};
    if (pend[3] && symQ.size() > 0) check({symRe, symIm}, symQ.pop_front());
    if (ringFrameValid && ringQ.size() > 0) check(ringFrame, ringQ.pop_front());
    nFrames <= nFrames + int'(ringFrameValid);
    nOut <= nOut + int'(outValid && outReady);
  end

  initial begin
    {cmpValid, cmpAcc, cmpAddr, dmemRdAddr, tracebackStart, lutWrite, lutAddr, lutData} = '0;
    {pointX, pointY, rotBits, shellBits, outReady, modelOn, modelSlow, rst_b} = '0;
    foreach (coef[k]) coef[k] = 16'($random(seed));
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    outReady <= 1'b1;
    @(posedge sys_clk);
    check(transitionHistory, 16'h0000);
    for (i = 0; i < 256; i++) begin
      lutWrite <= 1'b1;
      lutAddr <= i[7:0];
      lutData <= i[7:0] ^ 8'h5A;
      @(posedge sys_clk);
    end
    lutWrite <= 1'b0;
    hist = 16'h0000;
    for (i = 0; i < 24; i++) begin
      acc = (i == 0) ? 32'h80007FFF : (i == 1) ? 32'h5A5A5A5A : $random(seed);
      cmpValid <= 1'b1;
      cmpAcc <= acc;
      cmpAddr <= i[3:0];
      tbIn = 4'($random(seed));
      tracebackStart <= tbIn;
      @(posedge sys_clk);
      cmpValid <= 1'b0;
      dmemRdAddr <= i[3:0];
      tbExp = {tbIn[2:0], hist[15]};
      hist = {hist[14:0], $signed(acc[31:16]) < $signed(acc[15:0])};
      big = hist[0] ? acc[15:0] : acc[31:16];
      repeat (2) @(posedge sys_clk);
      check(transitionHistory, hist);
      check(testConditionFlag, hist[0]);
      check(dmemRdData, big);
      check(tbSt, tbExp);
    end
    // first symbol sees a cleared history, so random coefficients must not matter
    modelOn <= 1'b1;
    for (w = 0; w < 500 && takes < 1; w++) @(posedge sys_clk);
    modelOn <= 1'b0;
    foreach (coef[k]) coef[k] <= 16'h0000;
    repeat (20) @(posedge sys_clk);
    t0 = takes;
    outReady <= 1'b0;
    modelOn <= 1'b1;
    repeat (150) @(posedge sys_clk);
    check(takes - t0 >= 16 && takes - t0 <= 17, 1'b1);
    modelSlow <= 1'b1;
    for (w = 0; w < 400; w++) begin
      outReady <= 1'($random(seed));
      @(posedge sys_clk);
    end
    modelOn <= 1'b0;
    outReady <= 1'b1;
    repeat (80) @(posedge sys_clk);
    if (takes < 24) nMismatch++;
    check(nOut, takes);
    check(nFrames, takes / 8);
    check(symQ.size(), 0);
    report_and_stop();
  end
endmodule : tb

// [testbench/trb_backend_asserts.sv]
// concurrent checks on the trellis receiver back end top ports
// assumes a bind onto trb_receiver_backend, one clock and active-low reset
`timescale 1ns/1ps
module trb_backend_asserts (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmpValid,
  input wire logic [31:0] cmpAcc,
  input wire logic [15:0] transitionHistory,
  input wire logic testConditionFlag,
  input wire logic decValid,
  input wire logic decReady,
  input wire logic signed [15:0] symRe,
  input wire logic ringFrameValid,
  input wire logic [15:0] outData,
  input wire logic outValid,
  input wire logic outReady
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  hist_shift_a: assert property (cmpValid |=> transitionHistory[15:1] == $past(transitionHistory[14:0]))
    else $error("history did not move up one place");
  cmp_decision_a: assert property (cmpValid |=> transitionHistory[0] ==
    ($signed($past(cmpAcc[31:16])) < $signed($past(cmpAcc[15:0])))) else $error("compare decision wrong");
  flag_copy_a: assert property (cmpValid |=> testConditionFlag == transitionHistory[0])
    else $error("flag differs from newest decision");
  hist_hold_a: assert property (!cmpValid |=> $stable(transitionHistory))
    else $error("history changed without a compare");
  take_gap_a: assert property (decValid && decReady |=> !decReady [*2])
    else $error("decision accepted too soon");
  sym_cause_a: assert property ($changed(symRe) |-> $past(decValid && decReady, 3))
    else $error("symbol changed without a decision");
  frame_pulse_a: assert property (ringFrameValid |=> !ringFrameValid [*8])
    else $error("frame strobe repeated too soon");
  out_hold_a: assert property (outValid && !outReady |=> outValid && $stable(outData))
    else $error("output word dropped while stalled");
  reset_clear_a: assert property ($rose(rst_b) |-> transitionHistory == 16'h0000 && !outValid && !ringFrameValid)
    else $error("state not cleared by reset");
endmodule : trb_backend_asserts
bind trb_receiver_backend trb_backend_asserts i_chk (.sys_clk(sys_clk), .rst_b(rst_b), .cmpValid(cmpValid),
  .cmpAcc(cmpAcc), .transitionHistory(transitionHistory), .testConditionFlag(testConditionFlag),
  .decValid(decValid), .decReady(decReady), .symRe(symRe), .ringFrameValid(ringFrameValid),
  .outData(outData), .outValid(outValid), .outReady(outReady));

// [testbench/trb_decoder_model.sv]
// decoder-side model offering decisions on the valid/ready handshake
// assumes the back end samples on the rising edge of sys_clk
`timescale 1ns/1ps
module trb_decoder_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic slow,
  input wire logic decReady,
  output logic decValid,
  output logic signed [15:0] decRe,
  output logic signed [15:0] decIm
);
  integer seed = 977;
  // a request is held until taken; idle lines keep changing so no stale value looks valid
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      decValid <= 1'b0;
      decRe <= 16'h0000;
      decIm <= 16'h0000;
    end else if (!decValid || decReady) begin
      decValid <= enable && !decValid && (!slow || $random(seed) % 3 == 0);
      decRe <= decValid ? ~decRe : 16'($random(seed));
      decIm <= decValid ? ~decIm : 16'($random(seed));
    end
  end
endmodule : trb_decoder_model
